/* inc/pm_map_pkg.sv */
// constants, modes and carrier types of the performance monitor map
package pm_map_pkg;
	// tally widths
	localparam int CRC_W  = 10;
	localparam int FER_W  = 12;
	localparam int ALIGNMENT_CHANGE_TALLY_W = 3;
	localparam int OOF_W  = 5;
	localparam int PRBS_W = 16;
	localparam int LCV_W  = 16;
	localparam int DDS_W  = 10;
	// indirect offsets, counter space
	localparam logic [6:0] OFS_CRC_LO  = 7'h00;
	localparam logic [6:0] OFS_CRC_HI  = 7'h01;
	localparam logic [6:0] OFS_FER_LO  = 7'h02;
	localparam logic [6:0] OFS_FER_HI  = 7'h03;
	localparam logic [6:0] OFS_ALIGNMENT_CHANGE_TALLY    = 7'h04;
	localparam logic [6:0] OFS_OOF     = 7'h05;
	localparam logic [6:0] OFS_PRBS_LO = 7'h06;
	localparam logic [6:0] OFS_PRBS_HI = 7'h07;
	localparam logic [6:0] OFS_LCV_LO  = 7'h08;
	localparam logic [6:0] OFS_LCV_HI  = 7'h09;
	localparam logic [6:0] OFS_DDS_LO  = 7'h0a;
	localparam logic [6:0] OFS_DDS_HI  = 7'h0b;
	// indirect offsets, signaling space
	localparam logic [6:0] OFS_SIG_FIRST = 7'h01;
	localparam logic [6:0] OFS_SIG_LAST  = 7'h18;
	localparam int         SIG_CHANNELS  = 24;
	// signaling register fields
	localparam int         SIG_EXTRACT_BIT = 4;
	localparam int         SIG_ABCD_MSB    = 3;
	localparam logic       SIG_EXTRACT_RST = 1'b1;
	localparam logic [3:0] SIG_ABCD_RST    = 4'h0;
	localparam logic [7:0] RD_DATA_RST     = 8'h00;
	// timing
	localparam int CLK_PERIOD_NS   = 40;
	localparam int SNAP_PERIOD_NS  = 1000000000;
	localparam int SNAP_PERIOD_CYC = SNAP_PERIOD_NS / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		FMT_SF  = 4'b0001,
		FMT_ESF = 4'b0010,
		FMT_DM  = 4'b0100,
		FMT_SLC = 4'b1000
	} frame_fmt_e;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       sigSpace;
		logic [6:0] addr;
		logic [7:0] wdata;
	} ind_req_s;

	typedef struct packed {
		logic crc;
		logic fbit;
		logic align;
		logic sync;
		logic prbs;
		logic bpv;
		logic b8zsCv;
		logic dds;
	} err_ev_s;

	typedef struct packed {
		logic       valid;
		logic [4:0] chan;
		logic [3:0] abcd;
	} sig_cap_s;
endpackage

/* hw/pm_tally.sv */
// one saturating error accumulator with its snapshot register
`timescale 1ns/100ps
`default_nettype none
module pm_tally
	import pm_map_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         clk_sys,  // system clock
	input  wire logic         arst_n,   // async reset, low
	input  wire logic         ev,       // one error event
	input  wire logic         snap,     // group snapshot pulse
	output logic      [W-1:0] snapVal   // snapshot value
);
	logic [W-1:0] acc_ff;
	logic [W-1:0] snap_ff;
	wire          atMax  = &acc_ff;
	// saturate rather than wrap so a flood never reads as few errors
	wire  [W-1:0] accInc = (ev && !atMax) ? W'(acc_ff + 1'b1) : acc_ff;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			acc_ff  <= '0;
			snap_ff <= '0;
		end else begin
			// same-cycle event lands in the closing interval
			acc_ff <= snap ? '0 : accInc;
			if (snap) begin
				snap_ff <= accInc;
			end
		end
	end
	assign snapVal = snap_ff;

	property p_snap_take;
		@(posedge clk_sys) disable iff (!arst_n)
		snap |=> snapVal == $past(accInc);
	endproperty
	a_snap_take: assert property (p_snap_take)
		else $error("snapshot missed accumulator value");

	property p_acc_restart;
		@(posedge clk_sys) disable iff (!arst_n)
		snap |=> acc_ff == '0;
	endproperty
	a_acc_restart: assert property (p_acc_restart)
		else $error("accumulator not cleared after snapshot");

	property p_snap_hold;
		@(posedge clk_sys) disable iff (!arst_n)
		!snap |=> $stable(snapVal);
	endproperty
	a_snap_hold: assert property (p_snap_hold)
		else $error("snapshot changed without a snapshot pulse");
endmodule // pm_tally
`default_nettype wire

/* hw/pm_monitor.sv */
// performance monitor snapshots and per-channel signaling capture
// Notes on behaviour
// - ESF: 10-bit CRC-6 error tally, 00/01
// - SF/DM/SLC: framing bit error tally, 02/03
// - ESF: same tally counts alignment bit errors
// - 3-bit alignment change tally at 04
// - 5-bit sync loss tally at 05
// - 16-bit PRBS checker error tally, 06/07
// - 16-bit line tally: BPV or B8ZS violations
// - DM: 10-bit DDS pattern error tally, 0A/0B
// - channels 1..24 signaling at indirect 01..18
// - bit4 extract enable reset 1, ABCD read-only
// - manual trigger rising edge snapshots all tallies
// - periodic enable snapshots all tallies every second
`timescale 1ns/100ps
`default_nettype none
module pm_monitor
	import pm_map_pkg::*;
#(
	parameter int unsigned SNAP_CYCLES = SNAP_PERIOD_CYC
) (
	input  wire logic       clk_sys,     // system clock, 25 MHz
	input  wire logic       arst_n,      // async reset, low
	input  wire frame_fmt_e frameFmt,    // selected frame format
	input  wire logic       b8zsSel,     // 1: B8ZS decode, 0: AMI
	input  wire err_ev_s    errEv,       // error event pulses
	input  wire logic       manual_snapshot_trigger,  // 0->1 snapshots
	input  wire logic       periodic_snapshot_enable, // 1 s snapshots
	input  wire sig_cap_s   sigCap,      // extracted signaling word
	input  wire ind_req_s   indReq,      // indirect access request
	output logic [7:0]      rdData,      // indirect read data
	output logic            rdValid      // read data valid pulse
);
	////////////////////////////////////////////////////////////////////
	// snapshot timing
	localparam int CW = (SNAP_CYCLES > 1) ? $clog2(SNAP_CYCLES) : 1;
	localparam logic [CW-1:0] SEC_RELOAD = CW'(SNAP_CYCLES - 1);

	logic          trigPrev_ff;
	logic [CW-1:0] secCnt_ff;
	logic [CW-1:0] nxt_secCnt;

	wire manualRise = manual_snapshot_trigger && !trigPrev_ff;
	wire secTick    = periodic_snapshot_enable
	                  && (secCnt_ff == '0);
	wire snapPulse  = manualRise || secTick;

	// counter parks at reload while disabled, so the first periodic
	// snapshot comes a full second (SNAP_CYCLES clocks) after enabling
	assign nxt_secCnt = !periodic_snapshot_enable ? SEC_RELOAD :
	                    secTick ? SEC_RELOAD :
	                    CW'(secCnt_ff - 1'b1);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			trigPrev_ff <= 1'b0;
			secCnt_ff   <= SEC_RELOAD;
		end else begin
			trigPrev_ff <= manual_snapshot_trigger;
			secCnt_ff   <= nxt_secCnt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// event qualification by format and line code
	wire fmtEsf = (frameFmt == FMT_ESF);
	wire fmtDm  = (frameFmt == FMT_DM);
	wire fmtAny = (frameFmt == FMT_SF) || fmtEsf || fmtDm
	              || (frameFmt == FMT_SLC);

	wire crcEv  = errEv.crc && fmtEsf;
	// in ESF the framing tally counts alignment bit errors instead
	wire ferEv  = fmtEsf ? errEv.align : (errEv.fbit && fmtAny);
	wire cofaEv = errEv.align && !fmtEsf && fmtAny;
	wire oofEv  = errEv.sync && fmtAny;
	wire prbsEv = errEv.prbs;
	wire lcvEv  = b8zsSel ? errEv.b8zsCv : errEv.bpv;
	wire ddsEv  = errEv.dds && fmtDm;

	////////////////////////////////////////////////////////////////////
	// tallies, all loaded by the same snapshot pulse
	logic [CRC_W-1:0]  crcSnap;
	logic [FER_W-1:0]  ferSnap;
	logic [ALIGNMENT_CHANGE_TALLY_W-1:0] cofaSnap;
	logic [OOF_W-1:0]  oofSnap;
	logic [PRBS_W-1:0] prbsSnap;
	logic [LCV_W-1:0]  lcvSnap;
	logic [DDS_W-1:0]  ddsSnap;

	pm_tally #(.W(CRC_W)) uCrc (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.ev      (crcEv),
		.snap    (snapPulse),
		.snapVal (crcSnap)
	);
	pm_tally #(.W(FER_W)) uFer (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.ev      (ferEv),
		.snap    (snapPulse),
		.snapVal (ferSnap)
	);
	pm_tally #(.W(ALIGNMENT_CHANGE_TALLY_W)) uCofa (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.ev      (cofaEv),
		.snap    (snapPulse),
		.snapVal (cofaSnap)
	);
	pm_tally #(.W(OOF_W)) uOof (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.ev      (oofEv),
		.snap    (snapPulse),
		.snapVal (oofSnap)
	);
	pm_tally #(.W(PRBS_W)) uPrbs (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.ev      (prbsEv),
		.snap    (snapPulse),
		.snapVal (prbsSnap)
	);
	pm_tally #(.W(LCV_W)) uLcv (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.ev      (lcvEv),
		.snap    (snapPulse),
		.snapVal (lcvSnap)
	);
	pm_tally #(.W(DDS_W)) uDds (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.ev      (ddsEv),
		.snap    (snapPulse),
		.snapVal (ddsSnap)
	);

	////////////////////////////////////////////////////////////////////
	// counter space read decode, upper bits read as zero
	wire [6:0] a = indReq.addr;
	wire [7:0] pmonByte =
		(a == OFS_CRC_LO)  ? crcSnap[7:0] :
		(a == OFS_CRC_HI)  ? 8'(crcSnap[CRC_W-1:8]) :
		(a == OFS_FER_LO)  ? ferSnap[7:0] :
		(a == OFS_FER_HI)  ? 8'(ferSnap[FER_W-1:8]) :
		(a == OFS_ALIGNMENT_CHANGE_TALLY)    ? 8'(cofaSnap) :
		(a == OFS_OOF)     ? 8'(oofSnap) :
		(a == OFS_PRBS_LO) ? prbsSnap[7:0] :
		(a == OFS_PRBS_HI) ? prbsSnap[15:8] :
		(a == OFS_LCV_LO)  ? lcvSnap[7:0] :
		(a == OFS_LCV_HI)  ? lcvSnap[15:8] :
		(a == OFS_DDS_LO)  ? ddsSnap[7:0] :
		(a == OFS_DDS_HI)  ? 8'(ddsSnap[DDS_W-1:8]) :
		8'h00;

	////////////////////////////////////////////////////////////////////
	// per-channel signaling registers
	logic       sigExt_ff  [SIG_CHANNELS];
	logic [3:0] sigAbcd_ff [SIG_CHANNELS];

	wire       sigInRange = (a >= OFS_SIG_FIRST) && (a <= OFS_SIG_LAST);
	wire [4:0] sigIdx     = 5'(a - OFS_SIG_FIRST);
	wire       capInRange = (sigCap.chan >= 5'(OFS_SIG_FIRST))
	                        && (sigCap.chan <= 5'(OFS_SIG_LAST));
	wire [4:0] capIdx     = 5'(sigCap.chan - 5'(OFS_SIG_FIRST));
	wire       sigWr      = indReq.wr && indReq.sigSpace && sigInRange;

	wire [7:0] sigByte = !sigInRange ? 8'h00 :
		8'({sigExt_ff[sigIdx], sigAbcd_ff[sigIdx]});

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < SIG_CHANNELS; i++) begin
				sigExt_ff[i]  <= SIG_EXTRACT_RST;
				sigAbcd_ff[i] <= SIG_ABCD_RST;
			end
		end else begin
			for (int i = 0; i < SIG_CHANNELS; i++) begin
				if (sigWr && sigIdx == 5'(i)) begin
					sigExt_ff[i] <= indReq.wdata[SIG_EXTRACT_BIT];
				end
				// ABCD only follows the line while extraction is on
				if (sigCap.valid && capInRange && capIdx == 5'(i)
				    && sigExt_ff[i]) begin
					sigAbcd_ff[i] <= sigCap.abcd;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read answer, one cycle after the request
	logic [7:0] rdData_ff;
	logic       rdValid_ff;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdData_ff  <= RD_DATA_RST;
			rdValid_ff <= 1'b0;
		end else begin
			rdValid_ff <= indReq.rd;
			if (indReq.rd) begin
				rdData_ff <= indReq.sigSpace ? sigByte : pmonByte;
			end
		end
	end
	assign rdData  = rdData_ff;
	assign rdValid = rdValid_ff;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	sequence s_pm_rd(logic [6:0] ofs);
		indReq.rd && !indReq.sigSpace && indReq.addr == ofs;
	endsequence

	property p_crc_hi;
		s_pm_rd(OFS_CRC_HI) |=>
			rdValid && rdData == 8'($past(crcSnap) >> 8);
	endproperty
	a_crc_hi: assert property (p_crc_hi)
		else $error("crc high byte read wrong");

	property p_fer_hi;
		s_pm_rd(OFS_FER_HI) |=>
			rdValid && rdData == 8'($past(ferSnap) >> 8);
	endproperty
	a_fer_hi: assert property (p_fer_hi)
		else $error("framing high byte read wrong");

	property p_prbs_hi;
		s_pm_rd(OFS_PRBS_HI) |=> rdData == $past(prbsSnap[15:8]);
	endproperty
	a_prbs_hi: assert property (p_prbs_hi)
		else $error("prbs high byte read wrong");

	property p_crc_gate;
		!fmtEsf |-> !crcEv;
	endproperty
	a_crc_gate: assert property (p_crc_gate)
		else $error("crc counted outside ESF");

	property p_dds_gate;
		errEv.dds && !fmtDm |-> !ddsEv;
	endproperty
	a_dds_gate: assert property (p_dds_gate)
		else $error("dds counted outside DM");

	sequence s_trig_rise;
		!manual_snapshot_trigger ##1 manual_snapshot_trigger;
	endsequence

	property p_manual_snap;
		s_trig_rise |-> snapPulse;
	endproperty
	a_manual_snap: assert property (p_manual_snap)
		else $error("manual edge gave no snapshot");

	property p_periodic_span;
		secTick ##1 periodic_snapshot_enable |-> secCnt_ff == SEC_RELOAD;
	endproperty
	a_periodic_span: assert property (p_periodic_span)
		else $error("second counter not reloaded");

	property p_sig_write;
		sigWr |=> sigExt_ff[$past(sigIdx)] == $past(indReq.wdata[4]);
	endproperty
	a_sig_write: assert property (p_sig_write)
		else $error("extract enable not written");

	property p_sig_read;
		indReq.rd && indReq.sigSpace && !sigInRange |=> rdData == 8'h00;
	endproperty
	a_sig_read: assert property (p_sig_read)
		else $error("unmapped signaling address read nonzero");

	property p_sig_hold;
		sigCap.valid && capInRange && !sigExt_ff[capIdx] |=>
			sigAbcd_ff[$past(capIdx)] == $past(sigAbcd_ff[capIdx]);
	endproperty
	a_sig_hold: assert property (p_sig_hold)
		else $error("signaling captured while extraction off");
endmodule // pm_monitor
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the performance monitor map
`timescale 1ns/100ps
`default_nettype none
module tb
	import pm_map_pkg::*;
;
	logic       clk_sys;
	logic       arst_n;
	frame_fmt_e frameFmt;
	logic       b8zsSel;
	err_ev_s    errEv;
	logic       trig;
	logic       perEn;
	sig_cap_s   sigCap;
	ind_req_s   indReq;
	logic [7:0] rdData;
	logic       rdValid;
	int         n_fail;
	int         tests_run;

	pm_monitor #(.SNAP_CYCLES(16)) pm_monitor_i (
		.clk_sys                  (clk_sys),
		.arst_n                   (arst_n),
		.frameFmt                 (frameFmt),
		.b8zsSel                  (b8zsSel),
		.errEv                    (errEv),
		.manual_snapshot_trigger  (trig),
		.periodic_snapshot_enable (perEn),
		.sigCap                   (sigCap),
		.indReq                   (indReq),
		.rdData                   (rdData),
		.rdValid                  (rdValid)
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
			n_fail++;
		end
	endtask

	task automatic tally_and_finish();
		if (n_fail == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// one read: strobe for one edge, answer exactly one cycle later
	task automatic rd(input logic s, input logic [6:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		indReq <= '{1'b1, 1'b0, s, a, 8'h00};
		@(posedge clk_sys);
		indReq <= '0;
		#1;
		check({7'h00, rdValid}, 8'h01);
		check(rdData, e);
	endtask

	task automatic wr(input logic s, input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		indReq <= '{1'b0, 1'b1, s, a, d};
		@(posedge clk_sys);
		indReq <= '0;
	endtask

	task automatic ev(input logic [7:0] e, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			errEv <= e;
			@(posedge clk_sys);
			errEv <= '0;
		end
	endtask

	task automatic snap();
		@(posedge clk_sys);
		trig <= 1'b1;
		@(posedge clk_sys);
		@(posedge clk_sys);
		trig <= 1'b0;
	endtask

	task automatic rdAll(input logic [7:0] e [12]);
		for (int i = 0; i < 12; i++) begin
			rd(1'b0, 7'(i), e[i]);
		end
	endtask

	task automatic cap(input logic [4:0] ch, input logic [3:0] v);
		@(posedge clk_sys);
		sigCap <= '{1'b1, ch, v};
		@(posedge clk_sys);
		sigCap <= '0;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rdAll('{default: 8'h00});
		rd(1'b1, OFS_SIG_FIRST, 8'h10);
		rd(1'b1, OFS_SIG_LAST, 8'h10);
	endtask

	// esf: crc and alignment-bit errors counted, fbit/dds/cv not
	task automatic t_esf();
		frameFmt <= FMT_ESF;
		b8zsSel  <= 1'b0;
		ev(8'hff, 1);
		ev(8'h80, 2);
		snap();
		rdAll('{8'h03, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00,
			8'h01, 8'h00, 8'h00, 8'h00});
	endtask

	task automatic t_dm();
		frameFmt <= FMT_DM;
		b8zsSel  <= 1'b1;
		ev(8'hff, 2);
		ev(8'h40, 1);
		snap();
		rdAll('{8'h00, 8'h00, 8'h03, 8'h00, 8'h02, 8'h02, 8'h02, 8'h00,
			8'h02, 8'h00, 8'h02, 8'h00});
	endtask

	task automatic t_sf_slc();
		frame_fmt_e f [2];
		f = '{FMT_SF, FMT_SLC};
		for (int i = 0; i < 2; i++) begin
			frameFmt <= f[i];
			ev(8'h50, 1);
			snap();
			rd(1'b0, OFS_FER_LO, 8'h01);
			rd(1'b0, OFS_OOF, 8'h01);
		end
	endtask

	// 300 prbs errors reach the high byte; 3-bit tally saturates
	task automatic t_wide();
		frameFmt <= FMT_DM;
		ev(8'h28, 9);
		ev(8'h08, 291);
		snap();
		rd(1'b0, OFS_PRBS_LO, 8'h2c);
		rd(1'b0, OFS_PRBS_HI, 8'h01);
		rd(1'b0, OFS_ALIGNMENT_CHANGE_TALLY, 8'h07);
		snap();
		rd(1'b0, OFS_PRBS_HI, 8'h00);
	endtask

	task automatic t_periodic();
		ev(8'h08, 2);
		@(posedge clk_sys);
		perEn <= 1'b1;
		rd(1'b0, OFS_PRBS_LO, 8'h00);
		repeat (14) @(posedge clk_sys);
		rd(1'b0, OFS_PRBS_LO, 8'h02);
		perEn <= 1'b0;
		ev(8'h08, 1);
		repeat (20) @(posedge clk_sys);
		rd(1'b0, OFS_PRBS_LO, 8'h02);
	endtask

	task automatic t_signal();
		wr(1'b1, 7'h05, 8'h00);
		rd(1'b1, 7'h05, 8'h00);
		cap(5'd5, 4'hf);
		rd(1'b1, 7'h05, 8'h00);
		cap(5'd24, 4'h5);
		rd(1'b1, OFS_SIG_LAST, 8'h15);
		wr(1'b1, OFS_SIG_LAST, 8'hef);
		rd(1'b1, OFS_SIG_LAST, 8'h05);
		wr(1'b1, 7'h19, 8'h10);
		rd(1'b1, 7'h19, 8'h00);
		rd(1'b1, 7'h00, 8'h00);
		wr(1'b0, OFS_CRC_LO, 8'hff);
		rd(1'b0, OFS_CRC_LO, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		n_fail    = 0;
		tests_run = 0;
		arst_n    = 1'b0;
		frameFmt  = FMT_ESF;
		b8zsSel   = 1'b0;
		errEv     = '0;
		trig      = 1'b0;
		perEn     = 1'b0;
		sigCap    = '0;
		indReq    = '0;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset();
		t_esf();
		t_dm();
		t_sf_slc();
		t_wide();
		t_periodic();
		t_signal();
		tally_and_finish();
	end

	// the whole sequence needs well under 2000 cycles
	initial begin
		#(40 * 8000);
		n_fail++;
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
